//--- pkg/pic_defs.svh
// register offsets, reset values and vector addresses of the interrupt controller
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// ==========================================================
// data memory offsets (nibble registers)
`define PIC_ADDR_W 8
`define PIC_OFS_ENA 8'h50
`define PIC_OFS_ENB 8'h51
`define PIC_OFS_ENC 8'h52
`define PIC_OFS_END 8'h53
`define PIC_OFS_PNA 8'h55
`define PIC_OFS_PNB 8'h56
`define PIC_OFS_PNC 8'h57
`define PIC_OFS_PND 8'h58
`define PIC_OFS_GATE 8'h54

// ==========================================================
// field positions and reset values
`define PIC_GATE_BIT 0
`define PIC_RST_NIB 4'h0
`define PIC_RST_GATE 1'b0

// ==========================================================
// vector table: first start address and spacing
`define PIC_VEC_BASE 16'h0010
`define PIC_VEC_STEP 16'h0002
`define PIC_NSRC 14

`endif

//--- pkg/pic_pkg.sv
// types shared by the interrupt controller
package pic_pkg;
    // ==========================================================
    // cpu-side sequencer events for one cycle
    typedef struct packed {
        logic boundary;
        logic gate_open_instr;
        logic gate_close_instr;
        logic return_from_handler;
    } pic_cpu_s;

    // ==========================================================
    // data memory access from the core
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [3:0] wdata;
    } pic_mem_s;

    // arbitration result
    typedef enum logic [1:0] {
        PIC_IDLE,
        PIC_TAKE
    } pic_state_e;
endpackage

//--- rtl/pic_ctrl.sv
// fourteen-source priority interrupt controller with nibble registers
`timescale 1ns/10ps
`include "pic_defs.svh"

// Function
// - fourteen sources, four pins, ten internal
// - pins 0-3 vector 0010H to 0016H
// - timers, serial vector 0018H to 001EH
// - time-base taps vector 0020H to 0026H
// - melody 0028H, level detector 002AH
// - lowest start address wins arbitration
// - losing requests stay pending
// - vector address handed to cpu
// - gate is bit 0 of nibble
// - accepting interrupt closes the gate
// - return from handler opens gate
// - reset closes the gate
// - gate register read only from memory
// - request needs flag and enable both
// - accepting leaves enable bits unchanged
// - reset clears all enable banks
// - bank a enables pin sources
// - bank b enables timers and serial
// - new request latched into flag
// - software write of one raises request
// - accept clears flag, reset clears all
// - only enabled requests release halt
module pic_ctrl #(
    parameter int NSRC = `PIC_NSRC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // source events: 3:0 pins, 7:4 timer/serial, 11:8 taps, 12 melody, 13 level
    input wire logic [NSRC-1:0] src_pulse,
    // cpu sequencer
    input wire pic_pkg::pic_cpu_s cpu,
    input wire logic halt_state_flag,
    // data memory
    input wire pic_pkg::pic_mem_s mem,
    output logic [3:0] rdata_q,
    // to cpu
    output logic irq_take_q,
    output logic [15:0] vector_q,
    output logic halt_release_q,
    output logic global_irq_gate_q
);
    // ==========================================================
    // parameter check: the vector table is laid out for fourteen sources
    if (NSRC != `PIC_NSRC) begin : g_bad_nsrc
        $error("pic_ctrl serves exactly fourteen sources");
    end

    // ==========================================================
    // pin synchronisers: sources 3:0 come from port pins
    // two stages settle the pin, a third remembers it to find the edge
    // only the second and third stages feed logic beyond the chain, via the edge detect
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [NSRC-1:0] ev;                  // one-cycle request events
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
        end else begin
            pin_s1_q <= src_pulse[3:0];
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    // rising edge for pins, internal sources are already on this clock
    // a pin held high asks once; it must fall before it can ask again
    assign ev = {src_pulse[NSRC-1:4], pin_s2_q & ~pin_s3_q};

    // ==========================================================
    // enable banks and pending flags as one 16-bit image each
    logic [15:0] en_q;                    // bank d..a, 4 bits each
    logic [15:0] pend_q;
    logic [15:0] en_mask;                 // implemented bits
    // bits 15:14 have no source behind them and always read zero
    assign en_mask = 16'h3FFF;

    // index of a write into a nibble bank, or none
    // the subtraction wraps, so addresses below the base fall out of range
    function automatic logic [2:0] bank_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        bank_of = (d < 8'h04) ? {1'b1, d[1:0]} : 3'b000;
    endfunction

    // decoded windows, nibble masks and the written value spread over all nibbles
    logic [2:0] en_wsel, pn_wsel;
    logic [15:0] pn_wmask, en_wmask, pn_wval, en_wval;
    always_comb begin
        en_wsel = bank_of(mem.addr, `PIC_OFS_ENA);
        pn_wsel = bank_of(mem.addr, `PIC_OFS_PNA);
        en_wmask = 16'h0000;
        pn_wmask = 16'h0000;
        en_wval = {4{mem.wdata}};
        pn_wval = {4{mem.wdata}};
        if (mem.wr && en_wsel[2]) begin
            en_wmask[{en_wsel[1:0], 2'b00} +: 4] = 4'hF;
        end
        if (mem.wr && pn_wsel[2]) begin
            pn_wmask[{pn_wsel[1:0], 2'b00} +: 4] = 4'hF;
        end
    end

    // enable banks: only software writes them
    // reset leaves every source disabled
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= {4{`PIC_RST_NIB}};
        end else begin
            // accept never touches these bits
            en_q <= ((en_q & ~en_wmask) | (en_wval & en_wmask)) & en_mask;
        end
    end

    // ==========================================================
    // arbitration: lowest index is lowest start address
    logic [NSRC-1:0] live;                // flag and enable
    logic [NSRC-1:0] win_oh;
    logic [3:0] win_idx;
    logic any_live;
    assign live = pend_q[NSRC-1:0] & en_q[NSRC-1:0];
    // any_live also drives the halt release, without the gate
    assign any_live = |live;
    always_comb begin
        win_oh = '0;
        win_idx = 4'h0;
        // scan from the top so the lowest live index is the last one kept
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (live[i]) begin
                win_oh = '0;
                win_oh[i] = 1'b1;
                win_idx = 4'(i);
            end
        end
    end

    logic take;                           // accept this cycle
    // decide only on a boundary, so the running instruction finishes
    // before the vector is handed over
    assign take = cpu.boundary && global_irq_gate_q && any_live;

    // pending flags: set beats clear, losers stay
    // only the winner is cleared; losers wait for the next boundary
    // a written nibble takes the written value: one sets, zero clears
    // a new event is or-ed in last, so it beats a clear or a written zero
    logic [15:0] pend_clr;
    assign pend_clr = take ? {2'b00, win_oh} : 16'h0000;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= {4{`PIC_RST_NIB}};
        end else begin
            pend_q <= (((pend_q & ~pend_clr) & ~pn_wmask)
                      | (pn_wval & pn_wmask)
                      | {2'b00, ev}) & en_mask;
        end
    end

    // ==========================================================
    // global gate: instructions and accepts only, never data memory
    // an accept beats an open or a return in the same cycle, so the gate
    // can never stay open behind a vector that has just been handed over
    // data writes to the gate offset never reach this register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_gate_q <= `PIC_RST_GATE;
        end else if (take) begin
            global_irq_gate_q <= 1'b0;
        end else if (cpu.return_from_handler || cpu.gate_open_instr) begin
            global_irq_gate_q <= 1'b1;
        end else if (cpu.gate_close_instr) begin
            global_irq_gate_q <= 1'b0;
        end
    end

    // ==========================================================
    // vector handover to the cpu
    // the pulse lasts one cycle; the vector holds until the next accept
    // start addresses rise by one step for each step of priority
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_take_q <= 1'b0;
            vector_q <= 16'h0000;
        end else begin
            irq_take_q <= take;
            if (take) begin
                vector_q <= `PIC_VEC_BASE + 16'({12'h000, win_idx} * `PIC_VEC_STEP);
            end
        end
    end

    // halt release ignores the gate
    // any enabled pending request frees a halted cpu, the gate plays no part
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            halt_release_q <= 1'b0;
        end else begin
            halt_release_q <= halt_state_flag && any_live;
        end
    end

    // ==========================================================
    // register read port
    // read data follows the address one cycle later
    // the gate register shows its flag in bit 0 and zeros above
    // a read has no side effect on any flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 4'h0;
        end else begin
            if (en_wsel[2]) begin
                rdata_q <= en_q[{en_wsel[1:0], 2'b00} +: 4];
            end else if (pn_wsel[2]) begin
                rdata_q <= pend_q[{pn_wsel[1:0], 2'b00} +: 4];
            end else if (mem.addr == `PIC_OFS_GATE) begin
                rdata_q <= {3'b000, global_irq_gate_q};
            end else begin
                rdata_q <= 4'h0;
            end
        end
    end

    // ==========================================================
    // checks
    // every property runs on the system clock and rests during reset
    // the decision itself, as the arbiter makes it
    sequence s_accept;
        cpu.boundary && global_irq_gate_q && any_live;
    endsequence
    // what the cpu sees one cycle after the decision
    sequence s_handover;
        irq_take_q && !global_irq_gate_q;
    endsequence

    // software access to a pending bank that no accept disturbs
    sequence s_pend_write;
        mem.wr && pn_wsel[2] && !take;
    endsequence

    // a data write aimed at the gate offset with no gate instruction beside it
    sequence s_gate_poke;
        mem.wr && (mem.addr == `PIC_OFS_GATE) && !take && !cpu.gate_open_instr
            && !cpu.gate_close_instr && !cpu.return_from_handler;
    endsequence

    // accept gives the pulse and a closed gate together
    a_accept_hand: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_accept |=> s_handover) else $error("accept without handover");
    // gate is closed right after any accept
    a_take_closes_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take |=> !global_irq_gate_q) else $error("gate open after accept");
    // the vector handed over is the winner's start address
    a_take_vector_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take |=> irq_take_q
            && vector_q == `PIC_VEC_BASE + 16'({12'h000, $past(win_idx)} * 2))
        else $error("bad vector");
    // an accept needs the gate open in the decision cycle
    a_take_needs_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        irq_take_q |-> $past(global_irq_gate_q)) else $error("taken while closed");
    // an accept only ever follows an instruction boundary
    a_take_boundary: assert property (@(posedge ref_clk) disable iff (!rst_b)
        irq_take_q |-> $past(cpu.boundary)) else $error("taken inside an instruction");

    // requests that lose keep their flags for a later accept
    a_loser_stays: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take && $countones(live) > 1 && !mem.wr |=> |(pend_q & ~{2'b00, $past(win_oh)} & en_q))
        else $error("loser dropped");
    // the winner has no live request below it
    a_win_lowest: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take |-> (live & (win_oh - 14'h1)) == '0) else $error("not lowest");
    // an accept leaves every enable bit alone
    a_enables_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take && !mem.wr |=> en_q == $past(en_q)) else $error("enable changed");
    // an accept clears the winner's flag unless a new event arrives with it
    a_accept_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
        take && !mem.wr |=> (pend_q[NSRC-1:0] & $past(win_oh) & ~$past(ev)) == '0)
        else $error("winner flag kept");

    // every request event leaves its flag set
    a_event_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (|ev) |=> (pend_q[NSRC-1:0] & $past(ev)) == $past(ev)) else $error("event lost");
    // a software write sets its ones and clears its zeros
    a_sw_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_pend_write |=> (pend_q & $past(pn_wmask & en_mask))
            == $past((pn_wval | {2'b00, ev}) & pn_wmask & en_mask)) else $error("write lost");
    // the gate does not follow data writes
    a_gate_read_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_gate_poke |=> global_irq_gate_q == $past(global_irq_gate_q))
        else $error("gate written as data");

    // halt release only with a live request
    a_halt_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
        halt_release_q |-> $past(any_live)) else $error("disabled request freed halt");
    // a live request while halted frees the cpu on the next cycle
    a_halt_freed: assert property (@(posedge ref_clk) disable iff (!rst_b)
        halt_state_flag && any_live |=> halt_release_q) else $error("halt kept");
    // a return from handler opens the gate unless an accept closes it
    a_rti_opens: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cpu.return_from_handler && !take |=> global_irq_gate_q) else $error("rti failed");
endmodule

//--- verification/pic_cpu_seq.sv
// cpu sequencer model: instruction boundaries and gate instructions
`timescale 1ns/10ps
module pic_cpu_seq (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // requests from the bench
    input wire logic open_req,
    input wire logic close_req,
    input wire logic ret_req,
    // sequencer events
    output pic_pkg::pic_cpu_s cpu
);
    logic [1:0] cnt_q; // cycle within one instruction
    // ==========================================================
    // boundary every fourth cycle, instructions as one-cycle pulses
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 2'h0;
            cpu <= '0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            cpu.boundary <= (cnt_q == 2'h3);
            cpu.gate_open_instr <= open_req;
            cpu.gate_close_instr <= close_req;
            cpu.return_from_handler <= ret_req;
        end
    end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "pic_defs.svh"
module tb_top;
    logic ref_clk = 1'b0; // system clock
    logic rst_b = 1'b0; // reset, active low
    logic [13:0] src_pulse = 14'h0000; // request events
    logic halt_state_flag = 1'b0; // cpu halted
    pic_pkg::pic_mem_s mem = '0; // data memory access
    logic open_req = 1'b0; // ask for a gate-open instruction
    logic close_req = 1'b0; // ask for a gate-close instruction
    logic ret_req = 1'b0; // ask for a return from handler
    pic_pkg::pic_cpu_s cpu; // sequencer events
    logic [3:0] rdata_q;
    logic irq_take_q;
    logic [15:0] vector_q;
    logic halt_release_q;
    logic global_irq_gate_q;
    int n_mismatch = 0;
    int checks = 0;
    pic_ctrl u_pic_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .src_pulse(src_pulse), .cpu(cpu),
        .halt_state_flag(halt_state_flag), .mem(mem), .rdata_q(rdata_q),
        .irq_take_q(irq_take_q), .vector_q(vector_q), .halt_release_q(halt_release_q),
        .global_irq_gate_q(global_irq_gate_q));
    pic_cpu_seq u_pic_cpu_seq (.ref_clk(ref_clk), .rst_b(rst_b), .open_req(open_req),
        .close_req(close_req), .ret_req(ret_req), .cpu(cpu));
    // ==========================================================
    // clock and watchdog
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one nibble write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        mem <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        mem.wr <= 1'b0;
    endtask
    // read data lands one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [3:0] exp);
        @(posedge ref_clk);
        mem <= '{wr: 1'b0, addr: a, wdata: 4'h0};
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("rdata", {12'h000, rdata_q}, {12'h000, exp});
    endtask
    // watch a bounded span for an accept pulse
    task automatic wait_take(output logic got);
        got = 1'b0;
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (irq_take_q === 1'b1) got = 1'b1;
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        check("gate", {15'h0000, global_irq_gate_q}, 16'h0000);
        for (int a = 'h50; a <= 'h58; a++) rd(a[7:0], 4'h0);
        wr(`PIC_OFS_GATE, 4'hF);
        rd(`PIC_OFS_GATE, 4'h0);
    endtask
    // all fourteen pending, served one per return in address order
    task automatic t_priority();
        logic got;
        wr(`PIC_OFS_ENA, 4'hF);
        wr(`PIC_OFS_ENB, 4'hF);
        wr(`PIC_OFS_ENC, 4'hF);
        wr(`PIC_OFS_END, 4'h3);
        wr(`PIC_OFS_PNA, 4'hF);
        wr(`PIC_OFS_PNB, 4'hF);
        wr(`PIC_OFS_PNC, 4'hF);
        wr(`PIC_OFS_PND, 4'h3);
        for (int i = 0; i < `PIC_NSRC; i++) begin
            @(posedge ref_clk);
            ret_req <= 1'b1;
            @(posedge ref_clk);
            ret_req <= 1'b0;
            wait_take(got);
            check("take", {15'h0000, got}, 16'h0001);
            check("vector", vector_q, `PIC_VEC_BASE + `PIC_VEC_STEP * 16'(i));
            check("gate", {15'h0000, global_irq_gate_q}, 16'h0000);
        end
        rd(`PIC_OFS_PNA, 4'h0);
        rd(`PIC_OFS_PND, 4'h0);
        rd(`PIC_OFS_ENB, 4'hF);
    endtask
    // closed gate, disabled source, halt release and hardware events
    task automatic t_gate();
        logic got;
        @(posedge ref_clk);
        src_pulse[4] <= 1'b1;
        src_pulse[0] <= 1'b1;
        @(posedge ref_clk);
        src_pulse[4] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(`PIC_OFS_PNB, 4'h1);
        rd(`PIC_OFS_PNA, 4'h1);
        wr(`PIC_OFS_PNA, 4'h0);
        rd(`PIC_OFS_PNA, 4'h0);
        wait_take(got);
        check("take", {15'h0000, got}, 16'h0000);
        @(posedge ref_clk);
        halt_state_flag <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("wake", {15'h0000, halt_release_q}, 16'h0001);
        wr(`PIC_OFS_ENB, 4'h0);
        wr(`PIC_OFS_ENA, 4'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        check("wake", {15'h0000, halt_release_q}, 16'h0000);
        @(posedge ref_clk);
        open_req <= 1'b1;
        @(posedge ref_clk);
        open_req <= 1'b0;
        wait_take(got);
        check("take", {15'h0000, got}, 16'h0000);
        check("gate", {15'h0000, global_irq_gate_q}, 16'h0001);
        @(posedge ref_clk);
        close_req <= 1'b1;
        @(posedge ref_clk);
        close_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("gate", {15'h0000, global_irq_gate_q}, 16'h0000);
    endtask
    // ==========================================================
    // verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_priority();
        t_gate();
        print_verdict();
    end
endmodule
